// ---- logic/hdlc_poll_response_receive_modes.sv ----
`timescale 1ns/100ps
`default_nettype none
module hdlc_poll_response_receive_modes (
  input  wire logic                clock_i,
  input  wire logic                rst_n_i,
  input  wire logic                ce_i,
  input  wire logic                mode_select_hi_i,
  input  wire logic                mode_select_lo_i,
  input  wire logic                address_mode_bit_i,
  input  wire logic                auto_repeat_enable_i,
  input  wire logic [7:0]          rx_high_address_a_i,
  input  wire logic [7:0]          rx_high_address_b_i,
  input  wire logic [7:0]          rx_low_address_a_i,
  input  wire logic [7:0]          rx_low_address_b_i,
  input  wire logic                transmit_direct_cmd_i,
  input  wire logic                transmit_prepared_cmd_i,
  input  wire logic                tx_pool_free_i,
  input  wire logic                rx_pool_ack_i,
  input  wire logic                rx_frame_start_i,
  input  wire logic                rx_byte_valid_i,
  input  wire logic [7:0]          rx_byte_i,
  input  wire logic                rx_frame_end_i,
  input  wire logic                rx_crc_error_i,
  input  wire logic                rx_abort_i,
  output logic                     receive_fifo_wr_o,
  output logic [7:0]               receive_fifo_data_o,
  output logic [7:0]               rx_low_address_reg_o,
  output logic [7:0]               rx_control_field_reg_o,
  output logic [7:0]               rx_status_byte_o,
  output logic                     rx_message_end_irq_o,
  output logic                     rx_pool_full_irq_o,
  output logic                     rx_frame_overflow_irq_o,
  output logic                     tx_pool_ready_irq_o,
  output logic                     tx_message_repeat_irq_o,
  output logic                     tx_fifo_reset_o,
  output logic                     tx_fifo_writable_o,
  output logic                     resp_valid_o,
  output var hdlc_pkg::resp_kind_t resp_kind_o,
  output logic [7:0]               resp_ctrl_byte_o,
  output logic                     framing_bypass_o
);
  import hdlc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [2:0] cnt_reg;
  logic [6:0] level_reg;
  logic       addr_ok_reg;
  logic       store_reg;
  logic       cmd_prep_reg;
  logic       cmd_ack_reg;
  logic       frame_keep_reg;
  logic       frame_ovf_reg;
  logic       ovf_hold_reg;
  logic       direct_loaded_reg;
  logic       prep_loaded_reg;
  logic       sent_reg;

  // ----------------------------------------------------------------
  // mode and byte position decoding
  // ----------------------------------------------------------------
  wire logic [2:0] mode     = {mode_select_hi_i, mode_select_lo_i, address_mode_bit_i};
  wire logic is_auto        = (mode[2:1] == MODE_AUTO_HI);
  wire logic is_nonauto     = (mode[2:1] == MODE_NONAUTO_HI);
  wire logic is_t0          = (mode == MODE_TRANSP0);
  wire logic is_t1          = (mode == MODE_TRANSP1);
  wire logic is_ext         = (mode[2:1] == MODE_EXT_HI);
  wire logic two_byte       = address_mode_bit_i & (is_auto | is_nonauto);
  wire logic byte_ev        = ce_i & rx_byte_valid_i;
  wire logic end_ev         = ce_i & rx_frame_end_i & ~is_ext;
  // position of the control field after the opening flag
  wire logic [2:0] ctrl_idx = is_t0 ? 3'h1 : ((is_t1 | two_byte) ? 3'h2 : 3'h1);
  wire logic [2:0] low_idx  = ctrl_idx - 3'h1;
  wire logic [2:0] cmd_idx  = ctrl_idx + 3'h1;

  // address recognition, group addresses only on the high byte
  wire logic hi_match = (rx_byte_i == rx_high_address_a_i) | (rx_byte_i == rx_high_address_b_i)
                      | (rx_byte_i == GROUP_ADDR_A) | (rx_byte_i == GROUP_ADDR_B);
  wire logic lo_match = (rx_byte_i == rx_low_address_a_i) | (rx_byte_i == rx_low_address_b_i);
  wire logic addr_bad = ((two_byte | is_t1) & (cnt_reg == 3'h0) & ~hi_match)
                      | ((is_auto | is_nonauto) & (cnt_reg == low_idx) & ~lo_match);
  wire logic addr_ok_now = addr_ok_reg & ~addr_bad;
  wire logic ctrl_pos    = ~is_ext & (cnt_reg == ctrl_idx);
  wire logic low_pos     = is_ext | (cnt_reg == low_idx);
  wire logic cmd_pos     = is_auto & (cnt_reg == cmd_idx);

  // command byte classes, first data byte of an auto-mode i-frame
  wire logic is_iframe = ~rx_control_field_reg_o[0];
  wire logic byte_prep = (rx_byte_i[7:4] == CMD_PREP_NIB);
  wire logic byte_ack  = (rx_byte_i[7:4] == CMD_ACK_NIB_A) | (rx_byte_i[7:4] == CMD_ACK_NIB_B);
  wire logic auto_keep = cmd_pos ? (is_iframe & ~byte_prep & ~byte_ack) : store_reg;

  // ----------------------------------------------------------------
  // receive fifo writes and fill level
  // ----------------------------------------------------------------
  wire logic store_byte = addr_ok_now & (is_t0
                        | (is_t1 & (cnt_reg != 3'h0))
                        | (is_nonauto & (cnt_reg >= ctrl_idx))
                        | (is_auto & (cnt_reg > ctrl_idx) & auto_keep));
  wire logic data_want  = byte_ev & ((~is_ext & store_byte) | (mode == MODE_EXT1));
  wire logic stat_want  = end_ev & frame_keep_reg;
  wire logic fifo_full  = (level_reg == FIFO_BYTES);
  wire logic wr_ok      = (data_want | stat_want) & ~fifo_full;
  wire logic ovf_now    = (data_want | stat_want) & fifo_full;
  wire logic rx_data_overflow_bit        = frame_ovf_reg | ovf_now;
  wire logic [7:0] status_byte = ({7'h0, rx_data_overflow_bit} << STA_RDO_BIT)
                               | ({7'h0, rx_crc_error_i} << STA_CRC_BIT)
                               | ({7'h0, rx_abort_i} << STA_RAB_BIT);
  // a pool is released in whole, or whatever is left below a pool
  wire logic [6:0] release_n = (ce_i & rx_pool_ack_i)
                             ? ((level_reg < POOL_BYTES) ? level_reg : POOL_BYTES) : 7'h0;
  wire logic [6:0] level_next = level_reg + {6'h0, wr_ok} - release_n;
  wire logic pool_fill = wr_ok & (level_reg[4:0] == POOL_LAST);

  // ----------------------------------------------------------------
  // auto-mode frame end evaluation and response choice
  // ----------------------------------------------------------------
  wire logic good_end = end_ev & is_auto & addr_ok_reg & ~rx_crc_error_i & ~rx_abort_i;
  wire logic poll     = rx_control_field_reg_o[POLL_BIT];
  wire logic is_rr    = (rx_control_field_reg_o[3:0] == RR_CTRL_LOW);
  wire logic rr_poll  = good_end & is_rr & poll;
  wire logic rr_ack   = good_end & is_rr & ~poll;
  wire logic i_poll   = good_end & is_iframe & poll;
  wire logic prep_send   = i_poll & cmd_prep_reg & prep_loaded_reg;
  wire logic direct_send = rr_poll & direct_loaded_reg
                         & (~sent_reg | auto_repeat_enable_i);
  wire logic repeat_irq  = rr_poll & direct_loaded_reg & sent_reg
                         & ~auto_repeat_enable_i;
  wire logic pool_ack    = rr_ack
                         | (good_end & is_iframe & cmd_ack_reg & prep_loaded_reg);
  wire logic overflow_indication_bit         = ovf_hold_reg | rx_data_overflow_bit;
  wire logic [7:0] ctrl_resp = CTRL_RESP_BASE
                             | ({7'h0, auto_repeat_enable_i} << AUTO_REPEAT_ENABLE_BIT)
                             | ({7'h0, overflow_indication_bit} << DOV_BIT);
  // data frames outrank the rr and control answers
  wire resp_kind_t kind_next = (prep_send | direct_send) ? RESP_IDATA
                             : (rr_poll & ~direct_loaded_reg) ? RESP_RR
                             : i_poll ? RESP_CTRL : RESP_NONE;
  wire logic tx_commit = transmit_direct_cmd_i | transmit_prepared_cmd_i;

  // ----------------------------------------------------------------
  // frame parsing state
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt_reg        <= 3'h0;
      addr_ok_reg    <= 1'b0;
      store_reg      <= 1'b0;
      cmd_prep_reg   <= 1'b0;
      cmd_ack_reg    <= 1'b0;
      frame_keep_reg <= 1'b0;
      frame_ovf_reg  <= 1'b0;
    end else if (ce_i && rx_frame_start_i) begin
      cnt_reg        <= 3'h0;
      addr_ok_reg    <= 1'b1;
      store_reg      <= 1'b0;
      cmd_prep_reg   <= 1'b0;
      cmd_ack_reg    <= 1'b0;
      frame_keep_reg <= 1'b0;
      frame_ovf_reg  <= 1'b0;
    end else if (ce_i) begin
      if (byte_ev && cnt_reg != CNT_DATA) cnt_reg <= cnt_reg + 3'h1;
      if (byte_ev) addr_ok_reg <= addr_ok_now;
      if (byte_ev && cmd_pos) begin
        store_reg    <= auto_keep;
        cmd_prep_reg <= is_iframe & byte_prep;
        cmd_ack_reg  <= is_iframe & byte_ack;
      end
      if (data_want) frame_keep_reg <= 1'b1;
      if (ovf_now) frame_ovf_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // captured fields and receive fifo port
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rx_low_address_reg_o   <= 8'h00;
      rx_control_field_reg_o <= 8'h00;
      rx_status_byte_o       <= 8'h00;
      receive_fifo_wr_o      <= 1'b0;
      receive_fifo_data_o    <= 8'h00;
    end else if (ce_i) begin
      if (byte_ev && low_pos) rx_low_address_reg_o <= rx_byte_i;
      if (byte_ev && ctrl_pos) rx_control_field_reg_o <= rx_byte_i;
      if (stat_want) rx_status_byte_o <= status_byte;
      receive_fifo_wr_o   <= wr_ok;
      receive_fifo_data_o <= stat_want ? status_byte : rx_byte_i;
    end
  end

  // ----------------------------------------------------------------
  // fill level and overflow hold; a new overflow beats the release
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      level_reg    <= 7'h0;
      ovf_hold_reg <= 1'b0;
    end else if (ce_i) begin
      level_reg <= level_next;
      if (ovf_now) ovf_hold_reg <= 1'b1;
      else if (level_next == 7'h0) ovf_hold_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transmit bookkeeping; the tx fifo itself lives outside and is
  // only reset on acknowledge or forced reload, never on a resend
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      direct_loaded_reg  <= 1'b0;
      prep_loaded_reg    <= 1'b0;
      sent_reg           <= 1'b0;
      tx_fifo_writable_o <= 1'b1;
    end else if (ce_i) begin
      if (transmit_direct_cmd_i) direct_loaded_reg <= 1'b1;
      else if (pool_ack || repeat_irq) direct_loaded_reg <= 1'b0;
      if (transmit_prepared_cmd_i) prep_loaded_reg <= 1'b1;
      else if (pool_ack) prep_loaded_reg <= 1'b0;
      if (tx_commit || pool_ack || repeat_irq) sent_reg <= 1'b0;
      else if (direct_send || prep_send) sent_reg <= 1'b1;
      // a cpu commit wins over a pool freed by the transmitter
      if (tx_commit) tx_fifo_writable_o <= 1'b0;
      else if (pool_ack || repeat_irq || tx_pool_free_i) tx_fifo_writable_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // event pulses and response request
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rx_message_end_irq_o    <= 1'b0;
      rx_pool_full_irq_o      <= 1'b0;
      rx_frame_overflow_irq_o <= 1'b0;
      tx_pool_ready_irq_o     <= 1'b0;
      tx_message_repeat_irq_o <= 1'b0;
      tx_fifo_reset_o         <= 1'b0;
      resp_valid_o            <= 1'b0;
      resp_kind_o             <= RESP_NONE;
      resp_ctrl_byte_o        <= 8'h00;
      framing_bypass_o        <= 1'b0;
    end else if (ce_i) begin
      rx_message_end_irq_o    <= stat_want;
      rx_pool_full_irq_o      <= pool_fill;
      rx_frame_overflow_irq_o <= (rr_poll | i_poll) & ovf_hold_reg;
      tx_pool_ready_irq_o     <= pool_ack | tx_pool_free_i;
      tx_message_repeat_irq_o <= repeat_irq;
      tx_fifo_reset_o         <= pool_ack | repeat_irq;
      resp_valid_o            <= (kind_next != RESP_NONE);
      resp_kind_o             <= kind_next;
      resp_ctrl_byte_o        <= ctrl_resp;
      framing_bypass_o        <= is_ext;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_rr_ack;
    @(posedge clock_i) disable iff (!rst_n_i)
      rr_ack |=> tx_pool_ready_irq_o && tx_fifo_reset_o && tx_fifo_writable_o;
  endproperty
  a_rr_ack: assert property (p_rr_ack) else $error("rr ack not handled");

  property p_rr_resp;
    @(posedge clock_i) disable iff (!rst_n_i)
      (rr_poll && !direct_loaded_reg) |=> resp_valid_o && (resp_kind_o == RESP_RR);
  endproperty
  a_rr_resp: assert property (p_rr_resp) else $error("rr response missing");

  property p_prep;
    @(posedge clock_i) disable iff (!rst_n_i)
      (i_poll && cmd_prep_reg && prep_loaded_reg) |=> (resp_kind_o == RESP_IDATA);
  endproperty
  a_prep: assert property (p_prep) else $error("prepared data not sent");

  property p_cmd_ack;
    @(posedge clock_i) disable iff (!rst_n_i)
      (good_end && is_iframe && cmd_ack_reg && prep_loaded_reg)
        |=> tx_pool_ready_irq_o && tx_fifo_reset_o && !prep_loaded_reg;
  endproperty
  a_cmd_ack: assert property (p_cmd_ack) else $error("command ack ignored");

  property p_level;
    @(posedge clock_i) disable iff (!rst_n_i)
      level_reg <= FIFO_BYTES;
  endproperty
  a_level: assert property (p_level) else $error("fifo level past capacity");

  property p_pool_full;
    @(posedge clock_i) disable iff (!rst_n_i)
      (wr_ok && level_reg == 7'h1f) |=> rx_pool_full_irq_o && receive_fifo_wr_o;
  endproperty
  a_pool_full: assert property (p_pool_full) else $error("pool full missing");

  property p_ext_low;
    @(posedge clock_i) disable iff (!rst_n_i)
      (byte_ev && is_ext) |=> rx_low_address_reg_o == $past(rx_byte_i);
  endproperty
  a_ext_low: assert property (p_ext_low) else $error("ext byte not captured");

  property p_rfo;
    @(posedge clock_i) disable iff (!rst_n_i)
      ((rr_poll || i_poll) && ovf_hold_reg) |=> rx_frame_overflow_irq_o;
  endproperty
  a_rfo: assert property (p_rfo) else $error("frame overflow irq missing");

  property p_repeat;
    @(posedge clock_i) disable iff (!rst_n_i)
      (rr_poll && sent_reg && direct_loaded_reg && !auto_repeat_enable_i)
        |=> tx_message_repeat_irq_o && !resp_valid_o;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat irq missing");

  property p_t0_store;
    @(posedge clock_i) disable iff (!rst_n_i)
      (byte_ev && is_t0 && !rx_frame_start_i && addr_ok_reg && !fifo_full)
        |=> receive_fifo_wr_o;
  endproperty
  a_t0_store: assert property (p_t0_store) else $error("transparent byte lost");
endmodule : hdlc_poll_response_receive_modes
`default_nettype wire

// ---- pkg/hdlc_pkg.sv ----
`default_nettype none
package hdlc_pkg;
  // ----------------------------------------------------------------
  // mode codes {mode_select_hi, mode_select_lo, address_mode_bit}
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_AUTO_HI    = 2'h0;
  localparam logic [1:0] MODE_NONAUTO_HI = 2'h1;
  localparam logic [1:0] MODE_EXT_HI     = 2'h3;
  localparam logic [2:0] MODE_TRANSP0    = 3'h4;
  localparam logic [2:0] MODE_TRANSP1    = 3'h5;
  localparam logic [2:0] MODE_EXT1       = 3'h7;

  // ----------------------------------------------------------------
  // addresses, control field and command byte decoding
  // ----------------------------------------------------------------
  localparam logic [7:0] GROUP_ADDR_A  = 8'hfc;
  localparam logic [7:0] GROUP_ADDR_B  = 8'hfe;
  localparam logic [3:0] RR_CTRL_LOW   = 4'h1;
  localparam int         POLL_BIT      = 4;
  localparam logic [3:0] CMD_PREP_NIB  = 4'ha;
  localparam logic [3:0] CMD_ACK_NIB_A = 4'hd;
  localparam logic [3:0] CMD_ACK_NIB_B = 4'he;
  localparam logic [2:0] CNT_DATA      = 3'h4;

  // ----------------------------------------------------------------
  // control response byte 1 0 1 auto_repeat_enable 0 0 dov 1
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESP_BASE = 8'ha1;
  localparam int         AUTO_REPEAT_ENABLE_BIT       = 4;
  localparam int         DOV_BIT        = 1;

  // ----------------------------------------------------------------
  // receive status byte layout
  // ----------------------------------------------------------------
  localparam int STA_RDO_BIT = 6;
  localparam int STA_CRC_BIT = 5;
  localparam int STA_RAB_BIT = 4;

  // ----------------------------------------------------------------
  // receive fifo geometry
  // ----------------------------------------------------------------
  localparam logic [6:0] FIFO_BYTES = 7'h40;
  localparam logic [6:0] POOL_BYTES = 7'h20;
  localparam logic [4:0] POOL_LAST  = 5'h1f;

  typedef enum logic [1:0] {
    RESP_NONE  = 2'b00,
    RESP_RR    = 2'b01,
    RESP_CTRL  = 2'b10,
    RESP_IDATA = 2'b11
  } resp_kind_t;
endpackage : hdlc_pkg
`default_nettype wire

// ---- verif/group_controller_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// far-end poller: drives received frames byte by byte into the block
module group_controller_model (
  input  wire logic       clock_i,
  output logic            frame_start_o,
  output logic            byte_valid_o,
  output logic [7:0]      byte_o,
  output logic            frame_end_o,
  output logic            crc_error_o,
  output logic            abort_o
);
  initial begin
    {frame_start_o, byte_valid_o, frame_end_o, crc_error_o, abort_o} = 5'h00;
    byte_o = 8'h00;
  end
  // one frame: start, bytes back to back, end, then room for the answer
  task automatic send_frame(input logic [7:0] q[$], input logic crc, input logic ab);
    @(posedge clock_i) #1 frame_start_o = 1'b1;
    foreach (q[i]) begin
      @(posedge clock_i) #1 frame_start_o = 1'b0;
      byte_valid_o = 1'b1;
      byte_o = q[i];
    end
    @(posedge clock_i) #1 byte_valid_o = 1'b0;
    byte_o = ~byte_o; // released lines never hold the last value
    {frame_end_o, crc_error_o, abort_o} = {1'b1, crc, ab};
    @(posedge clock_i) #1 {frame_end_o, crc_error_o, abort_o} = 3'h0;
    repeat (3) @(posedge clock_i);
  endtask : send_frame
endmodule : group_controller_model
`default_nettype wire

// ---- verif/hdlc_poll_response_receive_modes_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module hdlc_poll_response_receive_modes_test;
  import hdlc_pkg::*;
  logic clock_i, rst_n_i, ce_i, hi, lo, address_mode_bit, auto_repeat_enable, dcmd, pcmd, pfree, pack;
  logic fs, bv, fe, crc, ab, fwr, rv, iq, pf, fo, pr, rp, fr, tx_fifo_writable, byp;
  logic [7:0] hia, hib, loa, lob, rb, fd, lreg, creg, sreg, cb, cbs;
  resp_kind_t kind;
  logic [1:0] ks;
  logic [5:0] ev;
  logic [7:0] fq[$], sq[$];
  int n_mismatch = 0, n_tests = 0;
  int npf;
  hdlc_poll_response_receive_modes dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .mode_select_hi_i(hi), .mode_select_lo_i(lo), .address_mode_bit_i(address_mode_bit),
    .auto_repeat_enable_i(auto_repeat_enable), .rx_high_address_a_i(hia), .rx_high_address_b_i(hib),
    .rx_low_address_a_i(loa), .rx_low_address_b_i(lob), .transmit_direct_cmd_i(dcmd),
    .transmit_prepared_cmd_i(pcmd), .tx_pool_free_i(pfree), .rx_pool_ack_i(pack),
    .rx_frame_start_i(fs), .rx_byte_valid_i(bv), .rx_byte_i(rb), .rx_frame_end_i(fe),
    .rx_crc_error_i(crc), .rx_abort_i(ab), .receive_fifo_wr_o(fwr),
    .receive_fifo_data_o(fd), .rx_low_address_reg_o(lreg), .rx_control_field_reg_o(creg),
    .rx_status_byte_o(sreg), .rx_message_end_irq_o(iq), .rx_pool_full_irq_o(pf),
    .rx_frame_overflow_irq_o(fo), .tx_pool_ready_irq_o(pr), .tx_message_repeat_irq_o(rp),
    .tx_fifo_reset_o(fr), .tx_fifo_writable_o(tx_fifo_writable), .resp_valid_o(rv), .resp_kind_o(kind),
    .resp_ctrl_byte_o(cb), .framing_bypass_o(byp));
  group_controller_model gc (.clock_i(clock_i), .frame_start_o(fs), .byte_valid_o(bv),
    .byte_o(rb), .frame_end_o(fe), .crc_error_o(crc), .abort_o(ab));
  // ----------------------------------------------------------------
  // pulse catcher: outputs stand one cycle, so latch them at the edge
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (rv) begin
      ks <= kind;
      cbs <= cb;
    end
    ev <= ev | {rp, pr, iq, fr, fo, rv};
    if (fwr) fq.push_back(fd);
    if (pf) npf <= npf + 1;
  end
  task automatic clr();
    ev = 6'h00;
    npf = 0;
    ks = 2'h0;
    fq.delete();
  endtask : clr
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string w);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t %s got %h want %h", $time, w, g, e);
    end
  endtask : chk
  task automatic chkq(input logic [7:0] e[$]);
    chk(fq.size(), e.size(), "fifo count");
    foreach (e[i]) chk(fq[i], e[i], "fifo byte");
  endtask : chkq
  // commit pulse for direct or prepared data
  task automatic commit(input logic prep);
    @(posedge clock_i) #1 {pcmd, dcmd} = {prep, ~prep};
    @(posedge clock_i) #1 {pcmd, dcmd} = 2'h0;
    @(posedge clock_i) #1 chk(tx_fifo_writable, 1'b0, "writable after commit");
  endtask : commit
  task automatic poll(input logic [7:0] q[$], input logic [5:0] e, input logic [1:0] k);
    // clear off the edge so the catcher cannot restore stale events
    @(posedge clock_i) #1 clr();
    gc.send_frame(q, 1'b0, 1'b0);
    chk(ev, e, "events");
    chk(ks, k, "response kind");
  endtask : poll
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clock_i);
    n_mismatch++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n_i, ce_i, hi, lo, address_mode_bit, auto_repeat_enable, dcmd, pcmd, pfree, pack} = 10'h100;
    {hia, hib, loa, lob} = 32'h4142_2122;
    clr();
    repeat (16) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    @(posedge clock_i) #1 chk({tx_fifo_writable, byp}, 2'b10, "reset levels");
    poll('{8'h21, 8'h11}, 6'h01, RESP_RR);
    commit(1'b0);
    poll('{8'h21, 8'h11}, 6'h01, RESP_IDATA);
    poll('{8'h22, 8'h11}, 6'h24, RESP_NONE);
    commit(1'b0);
    poll('{8'h21, 8'h01}, 6'h14, RESP_NONE);
    chk(tx_fifo_writable, 1'b1, "writable after ack");
    $display("direct data test done");
    auto_repeat_enable = 1'b1;
    commit(1'b1);
    poll('{8'h21, 8'h10, 8'ha5}, 6'h01, RESP_IDATA);
    poll('{8'h21, 8'h10, 8'ha0}, 6'h01, RESP_IDATA);
    poll('{8'h21, 8'h10, 8'hd3}, 6'h15, RESP_CTRL);
    poll('{8'h21, 8'h10, 8'h55, 8'h77}, 6'h09, RESP_CTRL);
    chk(cbs, CTRL_RESP_BASE | (8'h01 << AUTO_REPEAT_ENABLE_BIT), "control byte");
    chkq('{8'h55, 8'h77, 8'h00});
    @(posedge clock_i) #1 pack = 1'b1;
    @(posedge clock_i) #1 pack = 1'b0;
    $display("prepared data test done");
    // 64 data bytes: pool full twice, status byte finds no room
    sq = '{8'h21, 8'h10, 8'h55};
    repeat (63) sq.push_back(8'h66);
    poll(sq, 6'h09, RESP_CTRL);
    chk(npf, 2, "pool full count");
    chk(fq.size(), 64, "fifo fill");
    chk(sreg, 8'h01 << STA_RDO_BIT, "overflow status");
    chk(cbs, CTRL_RESP_BASE | (8'h01 << AUTO_REPEAT_ENABLE_BIT) | (8'h01 << DOV_BIT), "dov byte");
    poll('{8'h21, 8'h11}, 6'h03, RESP_RR);
    @(posedge clock_i) #1 pack = 1'b1;
    repeat (2) @(posedge clock_i);
    #1 pack = 1'b0;
    poll('{8'h21, 8'h11}, 6'h01, RESP_RR);
    $display("overflow test done");
    {hi, lo, address_mode_bit} = MODE_TRANSP0;
    clr();
    gc.send_frame('{8'haa, 8'hbb, 8'hcc}, 1'b1, 1'b0);
    chk({lreg, creg}, 16'haabb, "captured bytes");
    chk(ev, 6'h08, "message end only");
    chkq('{8'haa, 8'hbb, 8'hcc, 8'h01 << STA_CRC_BIT});
    chk(sreg, 8'h01 << STA_CRC_BIT, "status reg");
    $display("transparent test done");
    for (int m = 6; m < 8; m++) begin
      @(posedge clock_i) #1 {hi, lo, address_mode_bit} = 3'(m);
      clr();
      gc.send_frame('{8'h5a}, 1'b0, 1'b0);
      chk(byp, 1'b1, "bypass");
      chk(lreg, 8'h5a, "raw byte");
      chk(fq.size(), m - 6, "raw fifo count");
    end
    $display("extended test done");
    complete_run();
  end
endmodule : hdlc_poll_response_receive_modes_test
`default_nettype wire
